// file: include/tal_regs.vh
// Command codes, reset values, field positions and timing for the temperature alarm block.
// Included by the conversion sequencer and the top of the block, not by the synchroniser; definitions only.
`ifndef TAL_REGS_VH
`define TAL_REGS_VH

// Command bytes (read and write codes)
`define TAL_CMD_RD_TEMP_LO   8'h81
`define TAL_CMD_RD_TEMP_HI   8'h83
`define TAL_CMD_RD_STATUS    8'h85
`define TAL_CMD_RD_CFG       8'h87
`define TAL_CMD_WR_CFG       8'h92
`define TAL_CMD_RD_FCR       8'h89
`define TAL_CMD_WR_FCR       8'h94
`define TAL_CMD_RD_OVER_TEMP_LIMIT      8'ha1
`define TAL_CMD_WR_OVER_TEMP_LIMIT      8'ha4
`define TAL_CMD_RD_THYST     8'ha3
`define TAL_CMD_WR_THYST     8'ha6
`define TAL_CMD_RD_THIGH     8'h8f
`define TAL_CMD_WR_THIGH     8'h9a
`define TAL_CMD_RD_LOW_TEMP_LIMIT      8'h91
`define TAL_CMD_WR_LOW_TEMP_LIMIT      8'h9c
`define TAL_CMD_SOFT_POR     8'hf8
`define TAL_CMD_ONE_SHOT     8'h9e
`define TAL_CMD_WR_FAN_GAIN  8'hb6

// Reset values and the diode fault byte
`define TAL_RST_CFG          8'h00
`define TAL_RST_STATUS       8'h00
`define TAL_RST_FCR          8'h02
`define TAL_RST_OVER_TEMP_LIMIT         8'h64
`define TAL_RST_THYST        8'h5f
`define TAL_RST_THIGH        8'h7f
`define TAL_RST_LOW_TEMP_LIMIT         8'hc9
`define TAL_DIODE_FAULT_HI   8'h80

// Configuration fields and the fan-gain open-loop bit
`define TAL_CFG_ALERT_OFF    0
`define TAL_CFG_OT_OUT_MASK  1
`define TAL_CFG_OT_IN_INH    2
`define TAL_CFG_THERM_OPEN   3
`define TAL_CFG_WR_PROT      4
`define TAL_CFG_OT_POL       5
`define TAL_CFG_STANDBY      6
`define TAL_CFG_ALERT_MASK   7
`define TAL_FG_FAN_OPEN      0

// Status fields
`define TAL_ST_FAN_FAIL      0
`define TAL_ST_OVER_TEMP     1
`define TAL_ST_DIODE_OPEN    2
`define TAL_ST_LOW           3
`define TAL_ST_HIGH          4
`define TAL_ST_FULL_SCALE    5
`define TAL_ST_ALERT         6
`define TAL_ST_DRV_HOT       7

// Fan driver thermal shutdown, degrees C
`define TAL_DRV_HOT_SET      8'd150
`define TAL_DRV_HOT_CLR      8'd140

// Conversion period
`define TAL_CLK_MHZ          250
`define TAL_CONV_PERIOD_MS   500
`define TAL_CONV_PERIOD_CYC  (`TAL_CONV_PERIOD_MS * 1000 * `TAL_CLK_MHZ)

`endif

// file: hw/tal_sync3.v
// Three-stage synchroniser for a pin input; the output changes once stages two and three agree.
// Assumes a single core clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tal_sync3 #(
  parameter RST_VAL = 1'b1
) (
  input  wire i_core_clk,
  input  wire i_rst_b,
  input  wire i_pin,
  output wire o_level
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg lvl_ff;

  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      s1_ff  <= RST_VAL;
      s2_ff  <= RST_VAL;
      s3_ff  <= RST_VAL;
      lvl_ff <= RST_VAL;
    end else begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
    end
  end

  assign o_level = lvl_ff;
endmodule
`default_nettype wire

// file: hw/tal_conv.v
// Conversion sequencer: autoconvert timing, standby and single-conversion commands.
// Assumes the analog front end answers each start with one done pulse.
`timescale 1ns/100ps
`default_nettype none
`include "tal_regs.vh"
module tal_conv #(
  parameter P_PERIOD = `TAL_CONV_PERIOD_CYC
) (
  input  wire i_core_clk,
  input  wire i_rst_b,
  input  wire i_standby,
  input  wire i_one_shot,
  input  wire i_adc_done,
  output reg  o_conv_start,
  output reg  o_conv_end,
  output wire o_busy
);
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_CONV = 3'b010;
  localparam [2:0] S_WAIT = 3'b100;
  localparam [31:0] PERIOD_FULL = P_PERIOD - 1;
  localparam [26:0] PERIOD_M1   = PERIOD_FULL[26:0];

  reg [2:0]  st_ff;
  reg [2:0]  nxt_st;
  reg [26:0] cnt_ff;
  reg [26:0] nxt_cnt;
  reg        single_ff;
  reg        nxt_single;

  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_ff     <= S_WAIT;
      cnt_ff    <= 27'h0;
      single_ff <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      cnt_ff    <= nxt_cnt;
      single_ff <= nxt_single;
    end
  end

  always @* begin
    nxt_st       = st_ff;
    nxt_cnt      = cnt_ff;
    nxt_single   = single_ff;
    o_conv_start = 1'b0;
    o_conv_end   = 1'b0;
    case (st_ff)
      S_IDLE: begin
        if (!i_standby || i_one_shot) begin
          nxt_st       = S_CONV;
          nxt_single   = i_standby;
          o_conv_start = 1'b1;
        end
      end
      S_CONV: begin
        // One-shot is ignored here; a conversion is already running
        if (i_adc_done) begin
          o_conv_end = 1'b1;
          nxt_cnt    = PERIOD_M1;
          nxt_st     = i_standby ? S_IDLE : S_WAIT;
        end else if (i_standby && !single_ff) begin
          // Entering standby abandons the conversion; its result is dropped
          nxt_st = S_IDLE;
        end
      end
      S_WAIT: begin
        if (i_standby && !i_one_shot) begin
          nxt_st = S_IDLE;
        end else if (i_one_shot || cnt_ff == 27'h0) begin
          nxt_st       = S_CONV;
          nxt_single   = i_standby;
          o_conv_start = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 27'h1;
        end
      end
      default: begin
        nxt_st = S_WAIT;
      end
    endcase
    // No start while reset is low, so a soft reset never leaves the front end converting unseen
    if (!i_rst_b) begin
      o_conv_start = 1'b0;
    end
  end

  assign o_busy = st_ff[1];
endmodule
`default_nettype wire

// file: hw/tal_top.v
// Alarm, over-temperature, diode fault, conversion control and register file of a remote
// diode temperature monitor. The serial front end delivers decoded commands; the analog
// front end delivers conversion results.
// Contract
// - Over-temp out asserts while remote temperature exceeds the over-temp limit.
// - Once asserted, over-temp out holds until temperature drops below hysteresis.
// - Config bit 1 stops internal over-temp errors from driving the pin.
// - Config bit 5 picks pin polarity: 0 active low, 1 active high.
// - Active-low pin pulled low outside drives fan full and sets status 1.
// - Config bit 2 keeps an outside over-temp signal out of status bit 1.
// - Open or shorted diode loads the high temperature byte with 80h.
// - Open diode sets status 2 and alarm at conversion end; both clear on status read.
// - Alarm fires below low or above high limit unless config bit 7 masks.
// - Open diode, short diode, over-temp also fire the alarm and set flags.
// - Alarm stays latched until host reads the status register.
// - Alarm pin is active-low open-drain so several devices may share it.
// - Conversions continue under alarm; causes re-evaluated at every conversion end.
// - Temperature is 11-bit two's complement, 0.125 degree per LSB.
// - In standby a single-conversion command runs one conversion, then standby.
// - A single-conversion command during a running conversion is ignored.
// - In autoconvert, a single-conversion command between conversions starts one now.
// - Config bit 4 protects config bits 6..3, limit, hysteresis and rate; a fan-gain write still sets bit 3 while protected.
// - Config bit 3 opens thermal loop; set itself when fan gain bit 0 written.
// - Status 7 flags driver above 150 C; driver off until below 140 C.
// - Status 0 flags fan failure; status 5 flags full scale in closed loop.
// - Status bits 2..6 clear on status read; alarm follows, reasserts if persists.
`timescale 1ns/100ps
`default_nettype none
`include "tal_regs.vh"
module tal_top #(
  parameter P_CONV_PERIOD = `TAL_CONV_PERIOD_CYC
) (
  input  wire        i_core_clk,
  input  wire        i_rst_b,
  input  wire        i_rd_req,
  input  wire        i_xfer_done,
  input  wire [7:0]  i_xfer_cmd,
  input  wire [7:0]  i_xfer_wdata,
  output reg  [7:0]  o_rdata,
  output wire        o_conv_start,
  input  wire        i_adc_done,
  input  wire [10:0] i_adc_temp,
  input  wire        i_diode_open,
  input  wire        i_diode_short,
  input  wire        i_over_temp_in,
  output wire        o_over_temp_out,
  output wire        o_over_temp_oe,
  output wire        o_alert_out,
  output wire        o_alert_oe,
  input  wire        i_fan_fail,
  input  wire        i_fan_full_scale,
  input  wire        i_fan_closed_loop,
  input  wire [7:0]  i_drv_temp,
  output wire        o_fan_force_full,
  output wire        o_fan_drv_en,
  output wire        o_thermal_open,
  output wire [7:0]  o_fan_rate
);
  reg  [7:0]  cfg_ff;
  reg  [7:0]  fcr_ff;
  reg  [7:0]  over_temp_limit_ff;
  reg  [7:0]  thyst_ff;
  reg  [7:0]  thigh_ff;
  reg  [7:0]  low_temp_limit_ff;
  reg  [10:0] temp_ff;
  reg  [7:0]  temp_hi_ff;
  reg         hi_read_ff;
  reg         ot_int_ff;
  reg         alert_ff;
  reg  [6:2]  sticky_ff;
  reg  [6:2]  nxt_sticky;
  reg         drv_hot_ff;
  reg         soft_por_ff;
  reg  [7:0]  nxt_cfg;
  wire        rst_int_b;
  wire        conv_end;
  wire        conv_busy;
  wire        ot_pin_lvl;
  wire        ot_ext;
  wire        ot_status;
  wire        ot_next;
  wire        is_high;
  wire        is_low;
  wire        int_cause;
  wire        ext_cause;
  wire        wr_ok;
  wire        wr_prot;
  wire        one_shot;
  wire        stat_clr;
  wire [7:0]  status;
  wire [7:0]  temp_lo;

  // Signed compare of the 11-bit reading against a whole-degree limit
  function above;
    input [10:0] t;
    input [7:0]  lim;
    begin
      above = $signed(t) > $signed({lim, 3'b000});
    end
  endfunction

  function below;
    input [10:0] t;
    input [7:0]  lim;
    begin
      below = $signed(t) < $signed({lim, 3'b000});
    end
  endfunction

  // Software power-on reset acts like the reset pin, one cycle later
  assign rst_int_b = i_rst_b & ~soft_por_ff;

  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      soft_por_ff <= 1'b0;
    end else begin
      soft_por_ff <= i_xfer_done & (i_xfer_cmd == `TAL_CMD_SOFT_POR);
    end
  end

  assign wr_ok    = i_xfer_done & ~i_xfer_cmd[0];
  assign wr_prot  = cfg_ff[`TAL_CFG_WR_PROT];
  assign one_shot = i_xfer_done & (i_xfer_cmd == `TAL_CMD_ONE_SHOT);
  assign stat_clr = i_xfer_done & (i_xfer_cmd == `TAL_CMD_RD_STATUS);

  tal_conv #(
    .P_PERIOD (P_CONV_PERIOD)
  ) u_conv (
    .i_core_clk   (i_core_clk),
    .i_rst_b      (rst_int_b),
    .i_standby    (cfg_ff[`TAL_CFG_STANDBY]),
    .i_one_shot   (one_shot),
    .i_adc_done   (i_adc_done),
    .o_conv_start (o_conv_start),
    .o_conv_end   (conv_end),
    .o_busy       (conv_busy)
  );

  tal_sync3 #(
    .RST_VAL (1'b1)
  ) u_ot_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (rst_int_b),
    .i_pin      (i_over_temp_in),
    .o_level    (ot_pin_lvl)
  );

  // Configuration write with write protection and fan-gain side effect
  always @* begin
    nxt_cfg = cfg_ff;
    if (wr_ok && i_xfer_cmd == `TAL_CMD_WR_CFG) begin
      nxt_cfg = i_xfer_wdata;
      if (wr_prot) begin
        nxt_cfg[6:3] = cfg_ff[6:3];
      end
    end
    if (wr_ok && i_xfer_cmd == `TAL_CMD_WR_FAN_GAIN && i_xfer_wdata[`TAL_FG_FAN_OPEN]) begin
      nxt_cfg[`TAL_CFG_THERM_OPEN] = 1'b1;
    end
  end

  always @(posedge i_core_clk) begin
    if (!rst_int_b) begin
      cfg_ff   <= `TAL_RST_CFG;
      fcr_ff   <= `TAL_RST_FCR;
      over_temp_limit_ff  <= `TAL_RST_OVER_TEMP_LIMIT;
      thyst_ff <= `TAL_RST_THYST;
      thigh_ff <= `TAL_RST_THIGH;
      low_temp_limit_ff  <= `TAL_RST_LOW_TEMP_LIMIT;
    end else begin
      cfg_ff <= nxt_cfg;
      if (wr_ok && !wr_prot) begin
        if (i_xfer_cmd == `TAL_CMD_WR_OVER_TEMP_LIMIT) begin
          over_temp_limit_ff <= i_xfer_wdata;
        end
        if (i_xfer_cmd == `TAL_CMD_WR_THYST) begin
          thyst_ff <= i_xfer_wdata;
        end
        if (i_xfer_cmd == `TAL_CMD_WR_FCR) begin
          fcr_ff <= i_xfer_wdata;
        end
      end
      if (wr_ok && i_xfer_cmd == `TAL_CMD_WR_THIGH) begin
        thigh_ff <= i_xfer_wdata;
      end
      if (wr_ok && i_xfer_cmd == `TAL_CMD_WR_LOW_TEMP_LIMIT) begin
        low_temp_limit_ff <= i_xfer_wdata;
      end
    end
  end

  // Conversion results; a faulty diode replaces the reading with the fault pattern
  always @(posedge i_core_clk) begin
    if (!rst_int_b) begin
      temp_ff    <= 11'h0;
      temp_hi_ff <= 8'h00;
      hi_read_ff <= 1'b0;
    end else if (conv_end) begin
      hi_read_ff <= 1'b0;
      if (i_diode_open || i_diode_short) begin
        temp_ff    <= {`TAL_DIODE_FAULT_HI, 3'b000};
        temp_hi_ff <= `TAL_DIODE_FAULT_HI;
      end else begin
        temp_ff    <= i_adc_temp;
        temp_hi_ff <= i_adc_temp[10:3];
      end
    end else if (i_xfer_done && i_xfer_cmd == `TAL_CMD_RD_TEMP_HI) begin
      hi_read_ff <= 1'b1;
    end
  end

  // Limits are judged on the fresh reading at the end of each conversion
  assign is_high = above(i_adc_temp, thigh_ff);
  assign is_low  = below(i_adc_temp, low_temp_limit_ff);

  // Over-temperature with hysteresis; a faulty diode holds the previous state
  always @(posedge i_core_clk) begin
    if (!rst_int_b) begin
      ot_int_ff <= 1'b0;
    end else if (conv_end && !i_diode_open && !i_diode_short) begin
      if (above(i_adc_temp, over_temp_limit_ff)) begin
        ot_int_ff <= 1'b1;
      end else if (below(i_adc_temp, thyst_ff)) begin
        ot_int_ff <= 1'b0;
      end
    end
  end

  // Only the active-low pin is open drain and can be pulled low from outside
  assign ot_ext = ~cfg_ff[`TAL_CFG_OT_POL] & ~ot_pin_lvl &
                  ~(ot_int_ff & ~cfg_ff[`TAL_CFG_OT_OUT_MASK]);
  assign o_over_temp_out = cfg_ff[`TAL_CFG_OT_POL] & ot_int_ff &
                           ~cfg_ff[`TAL_CFG_OT_OUT_MASK];
  assign o_over_temp_oe  = cfg_ff[`TAL_CFG_OT_POL] |
                           (ot_int_ff & ~cfg_ff[`TAL_CFG_OT_OUT_MASK]);
  assign o_fan_force_full = ot_ext;
  assign ot_status = ot_int_ff | (ot_ext & ~cfg_ff[`TAL_CFG_OT_IN_INH]);

  // Alarm sees this conversion's over-temp decision, not the one from the conversion before
  assign ot_next = (i_diode_open | i_diode_short) ? ot_int_ff :
                   (above(i_adc_temp, over_temp_limit_ff) | (ot_int_ff & ~below(i_adc_temp, thyst_ff)));
  assign int_cause = ~cfg_ff[`TAL_CFG_ALERT_MASK] &
                     (is_high | is_low | i_diode_open | i_diode_short | ot_next);
  assign ext_cause = ot_ext;

  // Sticky flags: a set at conversion end wins over a clear in the same cycle
  always @* begin
    nxt_sticky = stat_clr ? 5'h00 : sticky_ff;
    if (conv_end) begin
      if (!i_diode_short && !i_diode_open) begin
        nxt_sticky[`TAL_ST_HIGH] = sticky_ff[`TAL_ST_HIGH] & ~stat_clr | is_high;
        nxt_sticky[`TAL_ST_LOW]  = sticky_ff[`TAL_ST_LOW] & ~stat_clr | is_low;
      end
      if (i_diode_open) begin
        nxt_sticky[`TAL_ST_DIODE_OPEN] = 1'b1;
      end
      if (int_cause || ext_cause) begin
        nxt_sticky[`TAL_ST_ALERT] = 1'b1;
      end
    end
    if (i_fan_full_scale && i_fan_closed_loop) begin
      nxt_sticky[`TAL_ST_FULL_SCALE] = 1'b1;
    end
  end

  always @(posedge i_core_clk) begin
    if (!rst_int_b) begin
      sticky_ff <= 5'h00;
      alert_ff  <= 1'b0;
    end else begin
      sticky_ff <= nxt_sticky;
      if (conv_end && (int_cause || ext_cause)) begin
        alert_ff <= 1'b1;
      end else if (stat_clr) begin
        alert_ff <= 1'b0;
      end
    end
  end

  // Open drain: the pin is only ever pulled low, the board provides the pull-up
  assign o_alert_out = 1'b0;
  assign o_alert_oe  = alert_ff & ~cfg_ff[`TAL_CFG_ALERT_OFF];

  // Fan driver thermal shutdown with a 10 degree window
  always @(posedge i_core_clk) begin
    if (!rst_int_b) begin
      drv_hot_ff <= 1'b0;
    end else if (i_drv_temp > `TAL_DRV_HOT_SET) begin
      // Read unsigned: a signed byte could never reach the trip point
      drv_hot_ff <= 1'b1;
    end else if (i_drv_temp < `TAL_DRV_HOT_CLR) begin
      drv_hot_ff <= 1'b0;
    end
  end

  assign o_fan_drv_en   = ~drv_hot_ff;
  assign o_thermal_open = cfg_ff[`TAL_CFG_THERM_OPEN];
  assign o_fan_rate     = fcr_ff;

  assign status = {drv_hot_ff, sticky_ff, ot_status, i_fan_fail};
  // Bit 4 warns that the high byte was not read first from this conversion
  assign temp_lo = {temp_ff[2:0], ~hi_read_ff, 4'h0};

  always @(posedge i_core_clk) begin
    if (!rst_int_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd_req) begin
      case (i_xfer_cmd)
        `TAL_CMD_RD_TEMP_LO: o_rdata <= temp_lo;
        `TAL_CMD_RD_TEMP_HI: o_rdata <= temp_hi_ff;
        `TAL_CMD_RD_STATUS:  o_rdata <= status;
        `TAL_CMD_RD_CFG:     o_rdata <= cfg_ff;
        `TAL_CMD_RD_FCR:     o_rdata <= fcr_ff;
        `TAL_CMD_RD_OVER_TEMP_LIMIT:    o_rdata <= over_temp_limit_ff;
        `TAL_CMD_RD_THYST:   o_rdata <= thyst_ff;
        `TAL_CMD_RD_THIGH:   o_rdata <= thigh_ff;
        `TAL_CMD_RD_LOW_TEMP_LIMIT:    o_rdata <= low_temp_limit_ff;
        default:             o_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: sim/tal_afe_model.sv
// Analog front end stand-in: answers every conversion start with one done pulse.
// Assumes starts come from tal_top; the bench sets the latency and the result.
`timescale 1ns/100ps
`default_nettype none
module tal_afe_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_conv_start,
  input  wire logic [4:0]  i_lat,
  input  wire logic [12:0] i_res,
  output logic             o_done,
  output logic [12:0]      o_res
);
  logic [4:0] cnt_ff = 5'h00;

  always @(posedge i_core_clk) begin
    if (i_conv_start) begin
      cnt_ff <= i_lat;
    end else if (cnt_ff != 5'h00) begin
      cnt_ff <= cnt_ff - 5'h01;
    end
  end

  assign o_done = (cnt_ff == 5'h01);
  // Result is junk outside the done cycle, so a late or early sample shows up
  assign o_res  = o_done ? i_res : ~i_res;
endmodule
`default_nettype wire

// file: sim/tal_top_assertions.sv
// Checker bound to tal_top: alarm latch, over-temp pin and conversion start rules.
// Assumes one core clock with a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tal_top_chk (
  input wire logic       i_core_clk,
  input wire logic       i_rst_b,
  input wire logic       i_xfer_done,
  input wire logic [7:0] i_xfer_cmd,
  input wire logic       i_adc_done,
  input wire logic       i_over_temp_in,
  input wire logic       o_over_temp_oe,
  input wire logic       o_alert_out,
  input wire logic       o_alert_oe,
  input wire logic       o_conv_start,
  input wire logic       o_fan_force_full
);
  logic busy_ff;
  wire  cfg_or_por = i_xfer_done && (i_xfer_cmd == 8'h92 || i_xfer_cmd == 8'hf8);
  wire  nxt_busy   = o_conv_start || (busy_ff && !i_adc_done && !cfg_or_por);

  // Config writes may abandon a conversion, so they also end the busy window
  always @(posedge i_core_clk) begin
    busy_ff <= i_rst_b && nxt_busy;
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  AST_ALERT_OD: assert property (o_alert_out == 1'b0)
    else $error("alert line driven high");
  AST_ALERT_HOLD: assert property ($fell(o_alert_oe) |->
    ($past(i_xfer_done) && ($past(i_xfer_cmd) == 8'h85 || $past(i_xfer_cmd) == 8'h92))
    || ($past(i_xfer_done, 2) && $past(i_xfer_cmd, 2) == 8'hf8))
    else $error("alert released without a status read");
  AST_ALERT_CLR: assert property (i_xfer_done && i_xfer_cmd == 8'h85 && !i_adc_done
    && i_over_temp_in && $past(i_over_temp_in, 6) |=> !o_alert_oe)
    else $error("alert kept after status read");
  AST_OT_CAUSE: assert property ($changed(o_over_temp_oe) |-> $past(i_adc_done)
    || $past(i_xfer_done) || $past(i_xfer_done, 2))
    else $error("over-temp drive changed between conversions");
  AST_ONESHOT_IGN: assert property (o_conv_start |-> !busy_ff)
    else $error("conversion started during a conversion");
  AST_ONESHOT_GO: assert property (i_xfer_done && i_xfer_cmd == 8'h9e && !busy_ff
    && !i_adc_done |-> ##[0:1] o_conv_start)
    else $error("single conversion did not start");
  AST_FORCE_SET: assert property ((!i_over_temp_in && !o_over_temp_oe)[*6]
    |-> o_fan_force_full)
    else $error("outside over-temp did not force fan");
  AST_FORCE_CLR: assert property (i_over_temp_in[*6] |-> !o_fan_force_full)
    else $error("fan forced without outside over-temp");
endmodule

bind tal_top tal_top_chk u_chk (
  .i_core_clk, .i_rst_b, .i_xfer_done, .i_xfer_cmd, .i_adc_done, .i_over_temp_in,
  .o_over_temp_oe, .o_alert_out, .o_alert_oe, .o_conv_start, .o_fan_force_full
);
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for tal_top: register traffic, conversions, alarm and pin checks.
// Assumes tal_afe_model on the analog side and a pull-up on the over-temp pin.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rd = 1'b0;
  logic        xd = 1'b0;
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic [10:0] temp = 11'h0cd;
  logic        dopen = 1'b0;
  logic        dshort = 1'b0;
  logic        ext_low = 1'b0;
  logic        ffail = 1'b0;
  logic        ffs = 1'b0;
  logic        fcl = 1'b0;
  logic [4:0]  lat = 5'h06;
  logic [7:0]  drv = 8'h19;
  wire  [12:0] res;
  wire  [7:0]  rdata;
  wire  [7:0]  frate;
  wire         cs, adone, otin, otout, otoe, aloe, ffull, topen, fden;
  int          num_errors = 0;
  int          compares = 0;
  int          nst = 0;
  int          cyc = 0;

  always #2 clk = ~clk;
  assign otin = otoe ? otout : ~ext_low;

  tal_top #(.P_CONV_PERIOD(20)) DUT (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_rd_req(rd), .i_xfer_done(xd),
    .i_xfer_cmd(cmd), .i_xfer_wdata(wd), .o_rdata(rdata), .o_conv_start(cs),
    .i_adc_done(adone), .i_adc_temp(res[10:0]), .i_diode_open(res[12]),
    .i_diode_short(res[11]), .i_over_temp_in(otin), .o_over_temp_out(otout),
    .o_over_temp_oe(otoe), .o_alert_out(), .o_alert_oe(aloe), .i_fan_fail(ffail),
    .i_fan_full_scale(ffs), .i_fan_closed_loop(fcl), .i_drv_temp(drv),
    .o_fan_force_full(ffull), .o_fan_drv_en(fden), .o_thermal_open(topen), .o_fan_rate(frate)
  );

  tal_afe_model u_afe (
    .i_core_clk(clk), .i_conv_start(cs), .i_lat(lat),
    .i_res({dopen, dshort, temp}), .o_done(adone), .o_res(res)
  );

  always @(posedge clk) begin
    cyc <= cyc + 1;
    nst <= nst + (cs ? 1 : 0);
    if (cyc == 4000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk);
    cmd = c;
    wd = d;
    xd = 1'b1;
    @(negedge clk);
    xd = 1'b0;
  endtask

  // A zero mask reads without comparing; fin completes the transfer
  task automatic rc(input logic [7:0] c, input logic [7:0] e, input logic fin,
                    input logic [7:0] m = 8'hff);
    @(negedge clk);
    cmd = c;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    if (m != 8'h00) begin
      chk($sformatf("reg %h", c), rdata & m, e);
    end
    if (fin) begin
      xd = 1'b1;
      @(negedge clk);
      xd = 1'b0;
    end
  endtask

  task automatic cv;
    for (int i = 0; i < 100 && adone !== 1'b1; i++) begin
      @(negedge clk);
    end
    @(negedge clk);
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    rc(8'h85, 8'h00, 1'b0);
    rc(8'h87, 8'h00, 1'b0);
    rc(8'ha1, 8'h64, 1'b0);
    rc(8'ha3, 8'h5f, 1'b0);
    cv;
    rc(8'h83, 8'h19, 1'b1);
    rc(8'h81, 8'ha0, 1'b0, 8'hf0);
    $display("test reset and format done");
    temp = 11'h321;
    cv;
    chk("ot pin", {6'h00, otoe, otout}, 8'h02);
    rc(8'h85, 8'h42, 1'b1);
    chk("alert", {7'h00, aloe}, 8'h00);
    cv;
    chk("alert", {7'h00, aloe}, 8'h01);
    temp = 11'h302;
    cv;
    chk("ot pin", {6'h00, otoe, otout}, 8'h02);
    temp = 11'h2f7;
    cv;
    chk("ot oe", {7'h00, otoe}, 8'h00);
    rc(8'h85, 8'h00, 1'b1, 8'h00);
    wr(8'h92, 8'h02);
    temp = 11'h321;
    cv;
    chk("ot oe", {7'h00, otoe}, 8'h00);
    wr(8'h92, 8'h20);
    chk("ot pin", {6'h00, otoe, otout}, 8'h03);
    temp = 11'h0cd;
    cv;
    chk("ot pin", {6'h00, otoe, otout}, 8'h02);
    wr(8'h92, 8'h00);
    rc(8'h85, 8'h00, 1'b1, 8'h00);
    $display("test over-temp done");
    ext_low = 1'b1;
    repeat (8) @(negedge clk);
    chk("force", {7'h00, ffull}, 8'h01);
    rc(8'h85, 8'h02, 1'b1, 8'h02);
    wr(8'h92, 8'h04);
    rc(8'h85, 8'h00, 1'b1, 8'h02);
    ext_low = 1'b0;
    wr(8'h92, 8'h00);
    repeat (8) @(negedge clk);
    chk("force", {7'h00, ffull}, 8'h00);
    rc(8'h85, 8'h00, 1'b1, 8'h00);
    $display("test outside over-temp done");
    dopen = 1'b1;
    cv;
    chk("alert", {7'h00, aloe}, 8'h01);
    rc(8'h83, 8'h80, 1'b0);
    rc(8'h85, 8'h44, 1'b1, 8'h44);
    dopen = 1'b0;
    cv;
    rc(8'h85, 8'h00, 1'b1, 8'h44);
    dshort = 1'b1;
    cv;
    rc(8'h83, 8'h80, 1'b0);
    dshort = 1'b0;
    cv;
    rc(8'h85, 8'h00, 1'b1, 8'h00);
    $display("test diode done");
    wr(8'h9a, 8'h1e);
    temp = 11'h0f1;
    cv;
    rc(8'h85, 8'h50, 1'b0);
    rc(8'h85, 8'h50, 1'b1);
    chk("alert", {7'h00, aloe}, 8'h00);
    cv;
    chk("alert", {7'h00, aloe}, 8'h01);
    wr(8'h92, 8'h80);
    rc(8'h85, 8'h00, 1'b1, 8'h00);
    cv;
    chk("alert", {7'h00, aloe}, 8'h00);
    wr(8'h92, 8'h00);
    temp = 11'h647;
    cv;
    rc(8'h85, 8'h00, 1'b1, 8'h00);
    cv;
    rc(8'h85, 8'h48, 1'b1);
    $display("test limits done");
    wr(8'h94, 8'h04);
    wr(8'h92, 8'h10);
    wr(8'ha4, 8'h50);
    wr(8'h94, 8'h05);
    chk("rate", frate, 8'h04);
    rc(8'ha1, 8'h64, 1'b0);
    wr(8'h92, 8'h82);
    rc(8'h87, 8'h92, 1'b0);
    wr(8'hb6, 8'h01);
    chk("open loop", {7'h00, topen}, 8'h01);
    rc(8'h87, 8'h9a, 1'b0);
    wr(8'hf8, 8'h00);
    rc(8'h87, 8'h00, 1'b0);
    $display("test protect done");
    lat = 5'h0c;
    wr(8'h92, 8'h40);
    repeat (40) @(negedge clk);
    nst = 0;
    repeat (40) @(negedge clk);
    chk("starts", 8'(nst), 8'h00);
    wr(8'h9e, 8'h00);
    wr(8'h9e, 8'h00);
    repeat (40) @(negedge clk);
    chk("starts", 8'(nst), 8'h01);
    wr(8'h92, 8'h00);
    cv;
    nst = 0;
    wr(8'h9e, 8'h00);
    @(negedge clk);
    chk("starts", 8'(nst), 8'h01);
    $display("test one-shot done");
    ffail = 1'b1;
    fcl = 1'b1;
    ffs = 1'b1;
    repeat (2) @(negedge clk);
    rc(8'h85, 8'h21, 1'b0, 8'h21);
    ffail = 1'b0;
    ffs = 1'b0;
    rc(8'h85, 8'h00, 1'b1, 8'h00);
    rc(8'h85, 8'h00, 1'b0, 8'h21);
    drv = 8'h97;
    rc(8'h85, 8'h80, 1'b0, 8'h80);
    drv = 8'h8c;
    @(negedge clk);
    chk("drv en", {7'h00, fden}, 8'h00);
    drv = 8'h8b;
    @(negedge clk);
    chk("drv en", {7'h00, fden}, 8'h01);
    $display("test fan flags done");
    close_out();
  end
endmodule
`default_nettype wire
